// file: logic/fdps_map.svh
`ifndef FDPS_MAP_SVH
`define FDPS_MAP_SVH
// Functional notes
// - Host masks bits 15..8, 4 and 0 of the status word.
// - Host polls bit 7 only at program address or erasing sector.
// - After bit 7 turns true, host takes data from next read.
// - Timeout bit set: host rereads bit 7 before declaring failure.
// - Host confirms acceptance by bit 7 or bit 6 before bit 3.
// - Host reads status twice, compares toggle bit; same means done.
// - Still toggling with timeout: retest, then failure and reset.
// - Interrupted toggle polling restarts from the first double read.

// Host register offsets (word addresses on the software port)
`define FDPS_REG_CTRL 4'h0
`define FDPS_REG_ADDR 4'h1
`define FDPS_REG_DATA 4'h2
`define FDPS_REG_STAT 4'h3
`define FDPS_REG_RDAT 4'h4
`define FDPS_REG_LAST 4'h5
// Control field positions
`define FDPS_CTL_GO 0
`define FDPS_CTL_MODE_LO 1
`define FDPS_CTL_MODE_HI 2
// Status field positions
`define FDPS_ST_BUSY 0
`define FDPS_ST_DONE 1
`define FDPS_ST_FAIL 2
`define FDPS_ST_ERASING 3
`define FDPS_ST_SECTOR 4
// Status word bits
`define FDPS_DQ_POLL 7
`define FDPS_DQ_TOGGLE 6
`define FDPS_DQ_TIMEOUT 5
`define FDPS_DQ_ERASE_TMR 3
`define FDPS_DQ_SECT_TGL 2
// Polling word mask: bits 15..8, 4 and 0 are don't care
`define FDPS_POLL_MASK 16'h00ee
`define FDPS_RESET_CMD 16'h00f0
`define FDPS_RESET_ADDR 24'h000000
// Bus cycle timing, in system clocks (40 ns each)
`define FDPS_T_STROBE_NS 80
`define FDPS_STROBE_CYC ((`FDPS_T_STROBE_NS + 39) / 40)
`define FDPS_T_HIGH_NS 40
`define FDPS_HIGH_CYC ((`FDPS_T_HIGH_NS + 39) / 40)
`define FDPS_CNT_W 4
`endif

// file: logic/fdps_pkg.sv
package fdps_pkg;
    typedef enum logic [2:0] {
        FDPS_IDLE = 3'b000,
        FDPS_RD1 = 3'b001,
        FDPS_RD2 = 3'b011,
        FDPS_EVAL = 3'b010,
        FDPS_RECHK = 3'b110,
        FDPS_FINAL = 3'b111,
        FDPS_RST = 3'b101,
        FDPS_DONE = 3'b100
    } fdps_state_t;

    typedef enum logic [1:0] {
        FDPS_MODE_TOGGLE = 2'b00,
        FDPS_MODE_POLL = 2'b01,
        FDPS_MODE_READ = 2'b10,
        FDPS_MODE_WRITE = 2'b11
    } fdps_mode_t;
endpackage : fdps_pkg

// file: logic/fdps_bus_cycle.sv
`include "fdps_map.svh"
// One asynchronous read or write cycle on the flash pins
module fdps_bus_cycle (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic wr,
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] dq_in,
    output logic [23:0] a_out,
    output logic [15:0] dq_out,
    output logic dq_oe,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [15:0] rdata,
    output logic done
);
    logic [`FDPS_CNT_W-1:0] cnt_reg;
    logic [1:0] ph_reg;
    wire logic strobe_end = (ph_reg == 2'd1) && (cnt_reg == '0);
    wire logic high_end = (ph_reg == 2'd2) && (cnt_reg == '0);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg <= 2'd0;
            cnt_reg <= '0;
            a_out <= 24'h000000;
            dq_out <= 16'h0000;
            dq_oe <= 1'b0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            rdata <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (ph_reg == 2'd0 && start) begin
                ph_reg <= 2'd1;
                cnt_reg <= `FDPS_CNT_W'(`FDPS_STROBE_CYC - 1);
                a_out <= addr;
                dq_out <= wdata;
                dq_oe <= wr;
                ce_n <= 1'b0;
                oe_n <= wr;
                we_n <= ~wr;
            end else if (strobe_end) begin
                // Each read ends with a high strobe, so the device counts it
                ph_reg <= 2'd2;
                cnt_reg <= `FDPS_CNT_W'(`FDPS_HIGH_CYC - 1);
                if (!oe_n) begin
                    rdata <= dq_in;
                end
                ce_n <= 1'b1;
                oe_n <= 1'b1;
                we_n <= 1'b1;
            end else if (high_end) begin
                ph_reg <= 2'd0;
                dq_oe <= 1'b0;
                done <= 1'b1;
            end else if (ph_reg != 2'd0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    cycle_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(ce_n) |-> !ce_n [*2] ##1 ce_n) else $error("Strobe length wrong");
endmodule : fdps_bus_cycle

// file: logic/fdps_toggle_cmp.sv
// Compares a toggle bit between two consecutive status reads
module fdps_toggle_cmp (
    input wire logic [15:0] first,
    input wire logic [15:0] second,
    input wire logic [3:0] bit_sel,
    output logic toggling
);
    assign toggling = first[bit_sel] ^ second[bit_sel];
endmodule : fdps_toggle_cmp

// file: logic/fdps_host.sv
`include "fdps_map.svh"
// Host controller polling a NOR flash status overlay
module fdps_host (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [23:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);
    fdps_pkg::fdps_state_t state_reg;
    fdps_pkg::fdps_state_t state_next;
    fdps_pkg::fdps_mode_t mode_reg;
    logic [23:0] addr_reg;
    logic [15:0] data_reg;
    logic [15:0] first_reg;
    logic [15:0] second_reg;
    logic [15:0] rdat_reg;
    logic done_reg;
    logic fail_reg;
    logic erasing_reg;
    logic sector_reg;
    logic retry_reg;
    logic cyc_start;
    logic cyc_wr;
    logic [23:0] cyc_addr;
    logic [15:0] cyc_wdata;
    logic [15:0] cyc_rdata;
    logic cyc_done;
    logic tgl6;
    logic tgl2;

    wire logic busy = (state_reg != fdps_pkg::FDPS_IDLE) && (state_reg != fdps_pkg::FDPS_DONE);
    wire logic go = reg_wr && (reg_addr == `FDPS_REG_CTRL) && reg_wdata[`FDPS_CTL_GO] && !busy;
    wire logic poll_mode = (mode_reg == fdps_pkg::FDPS_MODE_POLL);
    wire logic [15:0] masked = cyc_rdata & `FDPS_POLL_MASK;
    // Bit 7 true matches the written bit 7 at the polled address
    wire logic poll_true = masked[`FDPS_DQ_POLL] == data_reg[`FDPS_DQ_POLL];
    wire logic timeout = masked[`FDPS_DQ_TIMEOUT];
    wire logic still_busy = poll_mode ? !poll_true : tgl6;

    fdps_bus_cycle u_cycle (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(cyc_start),
        .wr(cyc_wr),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .dq_in(flash_dq_in),
        .a_out(flash_addr),
        .dq_out(flash_dq_out),
        .dq_oe(flash_dq_oe),
        .ce_n(flash_ce_n),
        .oe_n(flash_oe_n),
        .we_n(flash_we_n),
        .rdata(cyc_rdata),
        .done(cyc_done)
    );

    fdps_toggle_cmp u_cmp6 (
        .first(first_reg & `FDPS_POLL_MASK),
        .second(masked),
        .bit_sel(4'(`FDPS_DQ_TOGGLE)),
        .toggling(tgl6)
    );
    fdps_toggle_cmp u_cmp2 (
        .first(first_reg & `FDPS_POLL_MASK),
        .second(masked),
        .bit_sel(4'(`FDPS_DQ_SECT_TGL)),
        .toggling(tgl2)
    );

    always_comb begin
        state_next = state_reg;
        cyc_start = 1'b0;
        cyc_wr = 1'b0;
        cyc_addr = addr_reg;
        cyc_wdata = data_reg;
        unique case (state_reg)
            fdps_pkg::FDPS_IDLE, fdps_pkg::FDPS_DONE: begin
                if (go) begin
                    state_next = fdps_pkg::FDPS_RD1;
                end
            end
            fdps_pkg::FDPS_RD1: begin
                cyc_start = 1'b1;
                cyc_wr = (mode_reg == fdps_pkg::FDPS_MODE_WRITE);
                state_next = fdps_pkg::FDPS_RD2;
            end
            fdps_pkg::FDPS_RD2: begin
                if (cyc_done) begin
                    if (mode_reg == fdps_pkg::FDPS_MODE_READ
                        || mode_reg == fdps_pkg::FDPS_MODE_WRITE) begin
                        state_next = fdps_pkg::FDPS_DONE;
                    end else begin
                        cyc_start = 1'b1;
                        state_next = fdps_pkg::FDPS_EVAL;
                    end
                end
            end
            fdps_pkg::FDPS_EVAL: begin
                if (cyc_done) begin
                    if (!still_busy) begin
                        cyc_start = 1'b1;
                        state_next = fdps_pkg::FDPS_FINAL;
                    end else if (timeout) begin
                        cyc_start = 1'b1;
                        state_next = fdps_pkg::FDPS_RECHK;
                    end else begin
                        cyc_start = 1'b1;
                        state_next = fdps_pkg::FDPS_EVAL;
                    end
                end
            end
            fdps_pkg::FDPS_RECHK: begin
                if (cyc_done) begin
                    if (!still_busy) begin
                        cyc_start = 1'b1;
                        state_next = fdps_pkg::FDPS_FINAL;
                    end else begin
                        cyc_start = 1'b1;
                        cyc_wr = 1'b1;
                        cyc_addr = `FDPS_RESET_ADDR;
                        cyc_wdata = `FDPS_RESET_CMD;
                        state_next = fdps_pkg::FDPS_RST;
                    end
                end
            end
            fdps_pkg::FDPS_FINAL, fdps_pkg::FDPS_RST: begin
                if (cyc_done) begin
                    state_next = fdps_pkg::FDPS_DONE;
                end
            end
        endcase
    end

    // Keep the last two reads: the newer one feeds the toggle compare, the older one the LAST register
    wire logic keep_read = cyc_done && (state_reg == fdps_pkg::FDPS_RD2
        || state_reg == fdps_pkg::FDPS_EVAL || state_reg == fdps_pkg::FDPS_RECHK);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= fdps_pkg::FDPS_IDLE;
            first_reg <= 16'h0000;
            second_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (keep_read) begin
                first_reg <= cyc_rdata;
                second_reg <= first_reg;
            end
        end
    end

    // Unmasked read data snapshot and result flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_reg <= 16'h0000;
            fail_reg <= 1'b0;
            done_reg <= 1'b0;
            erasing_reg <= 1'b0;
            sector_reg <= 1'b0;
            retry_reg <= 1'b0;
        end else begin
            if (go) begin
                fail_reg <= 1'b0;
                done_reg <= 1'b0;
                retry_reg <= 1'b0;
                erasing_reg <= 1'b0;
                sector_reg <= 1'b0;
            end
            // Sticky until the next go, so software still sees them once idle
            if (state_reg == fdps_pkg::FDPS_EVAL && cyc_done && still_busy) begin
                // Bit 3 only after acceptance seen
                if (masked[`FDPS_DQ_ERASE_TMR]) begin
                    erasing_reg <= 1'b1;
                end
                if (tgl2) begin
                    sector_reg <= 1'b1;
                end
            end
            if (state_reg == fdps_pkg::FDPS_RECHK && cyc_done) begin
                retry_reg <= 1'b1;
            end
            if (state_reg == fdps_pkg::FDPS_RST) begin
                fail_reg <= 1'b1;
            end
            if (state_next == fdps_pkg::FDPS_DONE && state_reg != fdps_pkg::FDPS_DONE) begin
                done_reg <= 1'b1;
            end
            if (cyc_done && (state_reg == fdps_pkg::FDPS_RD2
                || state_reg == fdps_pkg::FDPS_FINAL)) begin
                rdat_reg <= cyc_rdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= fdps_pkg::FDPS_MODE_TOGGLE;
            addr_reg <= 24'h000000;
            data_reg <= 16'h0000;
        end else if (reg_wr && !busy) begin
            // Writes to setup registers are ignored while a poll runs
            if (reg_addr == `FDPS_REG_CTRL) begin
                mode_reg <= fdps_pkg::fdps_mode_t'(
                    reg_wdata[`FDPS_CTL_MODE_HI:`FDPS_CTL_MODE_LO]);
            end
            if (reg_addr == `FDPS_REG_ADDR) begin
                addr_reg <= reg_wdata[23:0];
            end
            if (reg_addr == `FDPS_REG_DATA) begin
                data_reg <= reg_wdata[15:0];
            end
        end
    end

    wire logic [31:0] stat_word = {27'h0000000, sector_reg, erasing_reg, fail_reg,
        done_reg, busy};
    wire logic [31:0] rd_mux =
        (reg_addr == `FDPS_REG_CTRL) ? {29'h00000000, mode_reg, 1'b0} :
        (reg_addr == `FDPS_REG_ADDR) ? {8'h00, addr_reg} :
        (reg_addr == `FDPS_REG_DATA) ? {16'h0000, data_reg} :
        (reg_addr == `FDPS_REG_STAT) ? stat_word :
        (reg_addr == `FDPS_REG_RDAT) ? {16'h0000, rdat_reg} :
        (reg_addr == `FDPS_REG_LAST) ? {16'h0000, second_reg} : 32'h00000000;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // Reset only after a timeout recheck
    reset_after_chk_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == fdps_pkg::FDPS_RST |-> retry_reg || $past(state_reg) == fdps_pkg::FDPS_RECHK)
        else $error("Reset command without recheck");
    double_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state_reg == fdps_pkg::FDPS_EVAL) |-> $past(state_reg) == fdps_pkg::FDPS_RD2)
        else $error("Evaluation without double read");
    // Final data read starts on entry
    final_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state_reg == fdps_pkg::FDPS_FINAL) |-> !flash_ce_n && !flash_oe_n)
        else $error("No final data read");
    timeout_recheck_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == fdps_pkg::FDPS_EVAL && cyc_done && still_busy && timeout
        |=> state_reg == fdps_pkg::FDPS_RECHK)
        else $error("Timeout not rechecked");
    // New poll starts at first read
    restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go |=> state_reg == fdps_pkg::FDPS_RD1)
        else $error("Poll did not restart");
    erase_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(erasing_reg) |-> $past(state_reg) == fdps_pkg::FDPS_EVAL)
        else $error("Erase flag set outside evaluation");
    // Failure write is the reset command
    reset_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == fdps_pkg::FDPS_RST && !flash_we_n |-> flash_dq_out == `FDPS_RESET_CMD)
        else $error("Wrong reset command");
    // Bus never driven during a read
    write_dq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !flash_oe_n |-> !flash_dq_oe)
        else $error("Bus contention");
endmodule : fdps_host

// file: tb/fdps_flash_model.sv
module fdps_flash_model (
    input wire logic [23:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [15:0] dq_in,
    input wire logic erase_go,
    input wire logic [3:0] erase_sect,
    input wire logic stuck,
    input wire logic tmo_late,
    input wire logic [7:0] busy_len,
    output int resets,
    output logic [23:0] poll_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:255];
    logic [15:0] pdata = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] noise = 16'ha5c3;
    logic [7:0] left = 8'h00;
    logic [3:0] sect = 4'h0;
    logic erasing = 1'b0;
    logic tmo = 1'b0;
    logic tgl = 1'b0;
    logic tgl2 = 1'b0;
    wire rd = !ce_n && !oe_n;
    wire wr = !ce_n && !we_n;
    wire busy = (left != 8'h00) || tmo;
    wire in_sect = erasing && addr[7:4] == sect;
    wire prot = addr[7:4] == 4'hf;
    initial begin
        resets = 0;
        poll_addr = 24'h000000;
        dq_in = 16'h0000;
        for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
    end
    function automatic logic [15:0] status();
        logic [15:0] s;
        s = noise & 16'hff11;
        s[7] = erasing ? 1'b0 : ~pdata[7];
        s[6] = tgl;
        s[5] = tmo || (tmo_late && left == 8'h01);
        s[3] = erasing;
        s[2] = in_sect && tgl2;
        return s;
    endfunction : status
    always @(posedge rd) begin
        last = busy ? status() : mem[addr[7:0]];
        dq_in = last;
        if (busy) poll_addr = addr;
    end
    always @(negedge rd) begin
        if (busy) begin
            tgl = ~tgl;
            if (in_sect) tgl2 = ~tgl2;
            if (!tmo && left != 8'h00) left = left - 8'h01;
            if (left == 8'h00 && !tmo) erasing = 1'b0;
        end
        noise = {noise[14:0], noise[15] ^ noise[12]};
        // Released bus shows no stale value
        dq_in = ~last;
    end
    always @(negedge wr) begin
        if (dq_oe && !(erasing && !tmo)) begin
            if (dq_out == 16'h00f0) begin
                resets++;
                left = 8'h00;
                tmo = 1'b0;
                erasing = 1'b0;
            end else begin
                if (!prot) mem[addr[7:0]] = dq_out;
                pdata = dq_out;
                left = busy_len;
                tmo = stuck;
            end
        end
    end
    always @(posedge erase_go) begin
        erasing = 1'b1;
        sect = erase_sect;
        left = busy_len;
        tmo = stuck;
        for (int j = 0; j < 16; j++) mem[{erase_sect, j[3:0]}] = 16'hffff;
    end
endmodule : fdps_flash_model

// file: tb/tb_top.sv
`include "fdps_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [23:0] flash_addr;
    logic [15:0] flash_dq_out;
    logic [15:0] flash_dq_in;
    logic flash_dq_oe;
    logic flash_ce_n;
    logic flash_oe_n;
    logic flash_we_n;
    logic erase_go = 1'b0;
    logic stuck = 1'b0;
    logic tmo_late = 1'b0;
    logic [7:0] busy_len = 8'h03;
    int resets;
    logic [23:0] poll_addr;
    int failures = 0;
    int checks = 0;
    logic [31:0] seed = 32'h985e;
    logic [31:0] rd;
    logic [15:0] shadow [0:255];
    logic [23:0] a;
    logic [15:0] d;
    int r0;
    always #20 sys_clk = ~sys_clk;
    fdps_host DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n));
    fdps_flash_model flash (.addr(flash_addr), .dq_out(flash_dq_out), .dq_oe(flash_dq_oe),
        .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .dq_in(flash_dq_in),
        .erase_go(erase_go), .erase_sect(4'h6), .stuck(stuck), .tmo_late(tmo_late),
        .busy_len(busy_len), .resets(resets), .poll_addr(poll_addr));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs
    function automatic logic [15:0] arr(input logic [7:0] i);
        return {i, ~i};
    endfunction : arr
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wreg(input logic [3:0] ad, input logic [31:0] dd);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= dd;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] ad);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rreg
    task automatic start(input fdps_pkg::fdps_mode_t m, input logic [23:0] ad,
        input logic [15:0] dd);
        wreg(`FDPS_REG_ADDR, {8'h00, ad});
        wreg(`FDPS_REG_DATA, {16'h0000, dd});
        wreg(`FDPS_REG_CTRL, {29'h0, m, 1'b1});
    endtask : start
    task automatic wait_idle();
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 300; i++) begin
            rreg(`FDPS_REG_STAT);
            if (rd[`FDPS_ST_BUSY] === 1'b0) break;
        end
        check(rd & 32'h1, 32'h0, "hang");
    endtask : wait_idle
    task automatic expect_ok(input logic [15:0] e);
        check(rd & 32'h6, 32'h2, "status");
        rreg(`FDPS_REG_RDAT);
        check(rd, {16'h0000, e}, "data");
    endtask : expect_ok
    task automatic prog(input logic [23:0] ad, input logic [15:0] dd);
        start(fdps_pkg::FDPS_MODE_WRITE, ad, dd);
        wait_idle();
        shadow[ad[7:0]] = dd;
    endtask : prog
    initial begin
        #2000000;
        failures++;
        test_done();
    end
    initial begin
        for (int i = 0; i < 256; i++) shadow[i] = arr(i[7:0]);
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rreg(`FDPS_REG_STAT);
        check(rd, 32'h0, "stat reset");
        rreg(4'hf);
        check(rd, 32'h0, "unmapped");
        a = 24'h3c1a27;
        prog(a, 16'h00b5);
        start(fdps_pkg::FDPS_MODE_POLL, a, 16'h00b5);
        // Busy host must drop this write
        wreg(`FDPS_REG_ADDR, 32'h00000011);
        wait_idle();
        expect_ok(16'h00b5);
        check({8'h00, poll_addr}, {8'h00, a}, "poll place");
        rreg(`FDPS_REG_ADDR);
        check(rd, {8'h00, a}, "addr kept");
        prog(24'h000042, 16'h5a4c);
        start(fdps_pkg::FDPS_MODE_TOGGLE, 24'h000042, 16'h0000);
        wait_idle();
        expect_ok(16'h5a4c);
        for (int k = 0; k < 3; k++) begin
            a = (k == 2) ? 24'h000095 : 24'h000063;
            busy_len <= 8'h04;
            erase_go <= 1'b1;
            @(posedge sys_clk);
            erase_go <= 1'b0;
            for (int j = 0; j < 16; j++) shadow[{4'h6, j[3:0]}] = 16'hffff;
            start((k == 1) ? fdps_pkg::FDPS_MODE_POLL : fdps_pkg::FDPS_MODE_TOGGLE, a, 16'hffff);
            wait_idle();
            check(rd & 32'h8, 32'h8, "erasing");
            if (k != 1) check(rd & 32'h10, (k == 0) ? 32'h10 : 32'h0, "sector");
            expect_ok(shadow[a[7:0]]);
        end
        stuck <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            r0 = resets;
            prog(24'h0000c3, 16'h0081);
            start(k ? fdps_pkg::FDPS_MODE_POLL : fdps_pkg::FDPS_MODE_TOGGLE, 24'h0000c3, 16'h0081);
            wait_idle();
            check(rd & 32'h4, 32'h4, "fail flag");
            check(resets, r0 + 1, "reset sent");
        end
        stuck <= 1'b0;
        tmo_late <= 1'b1;
        r0 = resets;
        prog(24'h0000d0, 16'h0083);
        start(fdps_pkg::FDPS_MODE_POLL, 24'h0000d0, 16'h0083);
        wait_idle();
        expect_ok(16'h0083);
        check(resets, r0, "no reset");
        tmo_late <= 1'b0;
        // Protected program leaves the array alone
        start(fdps_pkg::FDPS_MODE_WRITE, 24'h0000f4, 16'h1234);
        wait_idle();
        start(fdps_pkg::FDPS_MODE_TOGGLE, 24'h0000f4, 16'h0000);
        wait_idle();
        expect_ok(shadow[8'hf4]);
        for (int n = 0; n < 8; n++) begin
            seed = xs(seed);
            a = seed[23:0];
            // Top sector is protected, so random programs avoid it
            if (a[7:4] == 4'hf) a[7:4] = 4'he;
            d = (seed[31:16] == 16'h00f0) ? 16'h00f1 : seed[31:16];
            busy_len <= {6'h00, seed[1:0]};
            prog(a, d);
            start(seed[2] ? fdps_pkg::FDPS_MODE_POLL : fdps_pkg::FDPS_MODE_TOGGLE, a, d);
            wait_idle();
            expect_ok(d);
            seed = xs(seed);
            start(fdps_pkg::FDPS_MODE_READ, seed[23:0], 16'h0000);
            wait_idle();
            expect_ok(shadow[seed[7:0]]);
            rreg(`FDPS_REG_LAST);
            check(rd, {16'h0000, d}, "last");
        end
        test_done();
    end
endmodule : tb_top
